// [hw/secure_unlock_pkg.sv]
package secure_unlock_pkg;

    localparam int unsigned KEY_BITS = 64;
    localparam logic [63:0] KEY_RESET = 64'h0000_0000_0000_0000;
    localparam logic [6:0]  CNT_RESET = 7'h00;
    localparam logic [6:0]  CNT_FULL  = 7'h40;
    localparam logic [6:0]  CNT_MAX   = 7'h7F;
    localparam logic        PIN_SYNC_RESET = 1'b0;
    // Security reads as in force during reset so a glitch never opens the part.
    localparam logic        SEC_SYNC_RESET = 1'b1;

    // Key value is arbitrary; each part is given its own customer key.
    localparam logic [63:0] CUSTOMER_KEY_DEFAULT = 64'h5A3C_96E1_0F7B_D428;

endpackage

// [hw/secure_unlock.sv]
`timescale 1ns/100ps
`default_nettype none

module secure_unlock
#(
    parameter logic [63:0] CUSTOMER_KEY = secure_unlock_pkg::CUSTOMER_KEY_DEFAULT
)
(
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic secure_en_i,
    input  wire logic tck_i,
    input  wire logic tdi_i,
    input  wire logic key_shift_i,
    input  wire logic ext_boot_req_i,
    output logic      emu_enable_o,
    output logic      ext_boot_en_o,
    output logic      rom_only_o,
    output logic      key_fail_o
);

    // Every pin but rst_i is sampled by mclk through two flops; tck is far slower.
    logic        tck_sync;
    logic        tdi_sync;
    logic        shf_sync;
    logic        sec_sync;
    logic        boot_sync;
    logic        tck_rise;
    logic        shift_end;
    logic [63:0] key_q;
    logic [63:0] key_d;
    logic [6:0]  cnt_q;
    logic [6:0]  cnt_d;
    logic        unlock_q;
    logic        unlock_d;
    logic        fail_q;

    secure_unlock_sync
    #(
        .RESET_VAL (secure_unlock_pkg::PIN_SYNC_RESET)
    )
    u_sync_tck
    (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pin_i  (tck_i),
        .sync_o (tck_sync)
    );

    secure_unlock_sync
    #(
        .RESET_VAL (secure_unlock_pkg::PIN_SYNC_RESET)
    )
    u_sync_tdi
    (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pin_i  (tdi_i),
        .sync_o (tdi_sync)
    );

    secure_unlock_sync
    #(
        .RESET_VAL (secure_unlock_pkg::PIN_SYNC_RESET)
    )
    u_sync_shift
    (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pin_i  (key_shift_i),
        .sync_o (shf_sync)
    );

    secure_unlock_sync
    #(
        .RESET_VAL (secure_unlock_pkg::SEC_SYNC_RESET)
    )
    u_sync_secure
    (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pin_i  (secure_en_i),
        .sync_o (sec_sync)
    );

    secure_unlock_sync
    #(
        .RESET_VAL (secure_unlock_pkg::PIN_SYNC_RESET)
    )
    u_sync_boot
    (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pin_i  (ext_boot_req_i),
        .sync_o (boot_sync)
    );

    secure_unlock_edge
    #(
        .RISE     (1'b1),
        .IDLE_VAL (secure_unlock_pkg::PIN_SYNC_RESET)
    )
    u_edge_tck
    (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .level_i (tck_sync),
        .pulse_o (tck_rise)
    );

    secure_unlock_edge
    #(
        .RISE     (1'b0),
        .IDLE_VAL (secure_unlock_pkg::PIN_SYNC_RESET)
    )
    u_edge_shift
    (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .level_i (shf_sync),
        .pulse_o (shift_end)
    );

    wire shift_bit = tck_rise & shf_sync;
    wire secured   = sec_sync;
    // Only an exact 64-bit load is checked, so a short or long scan never unlocks.
    wire key_ok    = (cnt_q == secure_unlock_pkg::CNT_FULL) && (key_q == CUSTOMER_KEY);

    always_comb
    begin
        key_d    = key_q;
        cnt_d    = cnt_q;
        unlock_d = unlock_q;
        if (shift_bit)
        begin
            key_d = {tdi_sync, key_q[63:1]};
            if (cnt_q != secure_unlock_pkg::CNT_MAX)
                cnt_d = cnt_q + 7'h01;
        end
        if (shift_end)
        begin
            cnt_d = secure_unlock_pkg::CNT_RESET;
            if (key_ok)
                unlock_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            key_q    <= secure_unlock_pkg::KEY_RESET;
            cnt_q    <= secure_unlock_pkg::CNT_RESET;
            unlock_q <= 1'b0;
            fail_q   <= 1'b0;
        end
        else
        begin
            key_q    <= key_d;
            cnt_q    <= cnt_d;
            unlock_q <= unlock_d;
            fail_q   <= shift_end & ~key_ok;
        end
    end

    assign emu_enable_o  = ~secured | unlock_q;
    assign rom_only_o    = secured;
    assign ext_boot_en_o = ~secured & boot_sync;
    assign key_fail_o    = fail_q;

endmodule // secure_unlock

// Two-flop synchroniser; the first stage may go metastable, so only the second is read.
module secure_unlock_sync
#(
    parameter logic RESET_VAL = secure_unlock_pkg::PIN_SYNC_RESET
)
(
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      sync_o
);

    logic meta_q;
    logic sync_q;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // secure_unlock_sync

// The history flop resets to the pin's idle level, so no false edge follows reset.
module secure_unlock_edge
#(
    parameter logic RISE     = 1'b1,
    parameter logic IDLE_VAL = secure_unlock_pkg::PIN_SYNC_RESET
)
(
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic level_i,
    output logic      pulse_o
);

    logic last_q;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            last_q <= IDLE_VAL;
        else
            last_q <= level_i;
    end

    wire rise_w = level_i & ~last_q;
    wire fall_w = last_q & ~level_i;

    assign pulse_o = RISE ? rise_w : fall_w;

endmodule // secure_unlock_edge

`default_nettype wire

// [verification/secure_unlock_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module secure_unlock_asserts(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic secure_en_i,
    input wire logic tck_i,
    input wire logic tdi_i,
    input wire logic key_shift_i,
    input wire logic ext_boot_req_i,
    input wire logic emu_enable_o,
    input wire logic ext_boot_en_o,
    input wire logic rom_only_o,
    input wire logic key_fail_o);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_boot_shut: assert property (rom_only_o |-> !ext_boot_en_o) else $error("boot");
    a_boot_pass: assert property (!rom_only_o |-> ext_boot_en_o == $past(ext_boot_req_i, 2))
        else $error("pass");
    a_open_late: assert property ($rose(emu_enable_o) && rom_only_o |-> !key_fail_o)
        else $error("open");
    a_wrong_kept: assert property (key_fail_o |-> $stable(emu_enable_o)) else $error("kept");
    a_fail_once: assert property (key_fail_o |=> !key_fail_o) else $error("pulse");
    a_open_holds: assert property ($past(emu_enable_o) && rom_only_o |-> emu_enable_o)
        else $error("hold");
    cover property (key_fail_o);
    cover property (emu_enable_o && rom_only_o);
    cover property (ext_boot_en_o);
endmodule // secure_unlock_asserts
bind secure_unlock secure_unlock_asserts u_chk (.*);
`default_nettype wire

// [verification/jtag_key_host.sv]
`timescale 1ns/100ps
`default_nettype none
module jtag_key_host(output var logic tck_o, tdi_o, shift_o);
    initial {tck_o, tdi_o, shift_o} = 3'b000;
    // Clock rests low between frames; data idles inverted so a stale bit never looks valid.
    task automatic send(input logic [63:0] key, input int n);
        shift_o = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            tdi_o = key[i % 64];
            #160 tck_o = 1'b1;
            #160 tck_o = 1'b0;
        end
        #160 shift_o = 1'b0;
        tdi_o = ~tdi_o;
        #400;
    endtask
endmodule // jtag_key_host
`default_nettype wire

// [verification/secure_unlock_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module secure_unlock_tb;
    localparam logic [63:0] KEY = secure_unlock_pkg::CUSTOMER_KEY_DEFAULT;
    logic mclk_i = 0, rst_i = 1, secure_en_i = 1, ext_boot_req_i = 1;
    logic tck_i, tdi_i, key_shift_i, emu_enable_o, ext_boot_en_o, rom_only_o, key_fail_o;
    int   n_fail = 0, check_count = 0, fails = 0;
    always #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) fails += int'(key_fail_o === 1'b1);
    secure_unlock dut (.*);
    jtag_key_host host (.tck_o(tck_i), .tdi_o(tdi_i), .shift_o(key_shift_i));
    task automatic chk(input string s, input logic [7:0] e);
        logic [7:0] g = {emu_enable_o, ext_boot_en_o, rom_only_o, 5'(fails)};
        check_count++;
        if (g !== e) begin n_fail++; $display("[FAIL] %s expected %h seen %h", s, e, g); end
        $display("%s done", s);
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_wrong;
        host.send(~KEY, 64);
        host.send(KEY, 63);
        chk("wrong", 8'h22);
    endtask
    task automatic t_right;
        host.send(KEY, 64);
        chk("right", 8'ha2);
    endtask
    task automatic t_reset;
        @(posedge mclk_i) #1 rst_i = 1;
        @(posedge mclk_i) #1 chk("reset", 8'h22);
        rst_i = 0;
    endtask
    task automatic t_open;
        @(posedge mclk_i) #1 secure_en_i = 0;
        repeat (4) @(posedge mclk_i);
        #1 chk("open", 8'hc2);
        ext_boot_req_i = 0;
        repeat (3) @(posedge mclk_i);
        #1 chk("noreq", 8'h82);
    endtask
    initial begin #200000; n_fail++; test_done; end
    initial
    begin
        repeat (10) @(posedge mclk_i);
        #1 rst_i = 0;
        t_wrong;
        t_right;
        t_reset;
        t_open;
        test_done;
    end
endmodule // secure_unlock_tb
`default_nettype wire
